// File: efs_pkg.sv
`default_nettype none
package efs_pkg;
   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

   // Control register fields, control and interrupt mask reset values.
   localparam int         CTRL_RETRY_BIT  = 0;
   localparam int         CTRL_CLEAR_BIT  = 1;
   localparam logic       CTRL_RETRY_RST  = 1'b0;
   localparam logic [3:0] IRQ_MASK_RST    = 4'h0;

   // Interrupt event bit positions.
   localparam int IRQ_STARTUP_FAULT = 0;
   localparam int IRQ_THERMAL_CUT   = 1;
   localparam int IRQ_OVERVOLT_CUT  = 2;
   localparam int IRQ_SWITCH_ON     = 3;
   localparam int IRQ_WIDTH         = 4;

   // Status register field positions.
   localparam int STAT_SWITCH_BIT = 6;
   localparam int STAT_LINE_BIT   = 7;
   localparam int STAT_FAULT_BIT  = 8;
   localparam int STAT_DRAIN_BIT  = 9;

   // Timing, each figure in its own unit, then converted at the clock rate.
   localparam real CLK_PERIOD_NS           = 25.0;
   localparam real INSERTION_WAIT_TIME_MS  = 13.7;
   localparam real DRAIN_ENABLE_TIME_MS    = 4.66;
   localparam real STARTUP_TIMEOUT_TIME_MS = 215.0;
   localparam real RETRY_TIME_MS           = 107.5;
   localparam real OVERVOLTAGE_CUT_TIME_US = 1.57;
   localparam int  INSERTION_WAIT_CYC  = $rtoi(INSERTION_WAIT_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int  DRAIN_ENABLE_CYC    = $rtoi(DRAIN_ENABLE_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int  STARTUP_TIMEOUT_CYC = $rtoi(STARTUP_TIMEOUT_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int  RETRY_CYC           = $rtoi(RETRY_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int  OVERVOLTAGE_CUT_CYC = $rtoi(OVERVOLTAGE_CUT_TIME_US * 1.0e3 / CLK_PERIOD_NS);
   localparam int  TIMER_WIDTH         = 24;

   // Sequencer states, one-hot.
   typedef enum logic [5:0] {
      ST_OFF    = 6'h01,
      ST_INSERT = 6'h02,
      ST_READY  = 6'h04,
      ST_START  = 6'h08,
      ST_ON     = 6'h10,
      ST_FAULT  = 6'h20
   } efs_state_t;
endpackage : efs_pkg
`default_nettype wire

// File: efs_sync.sv
`timescale 1ns/100ps
`default_nettype none
module efs_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : efs_sync
`default_nettype wire

// File: efs_timer.sv
`timescale 1ns/100ps
`default_nettype none
module efs_timer (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Control.
   input  wire logic        clear,
   input  wire logic        load,
   input  wire logic [23:0] load_value,
   // Result.
   output logic             expired
);
   logic [23:0] count;
   logic        armed;
   logic [23:0] next_count;
   logic        next_armed;

   always_comb begin
      next_count = count;
      next_armed = armed;
      if (load) begin
         next_count = load_value;
         next_armed = 1'b1;
      end else if (clear) begin
         next_count = 24'h000000;
         next_armed = 1'b0;
      end else if (armed && count != 24'h000000) begin
         next_count = count - 24'h000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 24'h000000;
         armed <= 1'b0;
      end else begin
         count <= next_count;
         armed <= next_armed;
      end
   end

   // Stays high after expiry until the timer is reloaded or cleared.
   assign expired = armed && (count == 24'h000000);
endmodule : efs_timer
`default_nettype wire

// File: efs_startup_protect_seq.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// (R1) Wait for bias and input above undervoltage, then run the insertion delay.
// (R2) After the delay, switch on only when enable and shared line are both high.
// (R3) Keep the switch off whenever enable or the shared line is low.
// (R4) Peers in parallel share one line so start, stop and faults happen together.
// (R5) Thermal cutoff turns the switch off regardless of anything else.
// (R6) Fixed undervoltage on bias and input; enable comparator offers adjustable one.
// (R7) Enable decodes to on, intermediate keep-state, and full shutdown levels.
// (R8) Intermediate enable held past the drain time turns on output drain.
// (R9) Enable below shutdown drops all state and clears latched faults.
// (R10) The switch stays off during the insertion delay whatever enable shows.
// (R11) Input overvoltage turns the switch off within the cut time.
// (R12) After overvoltage clears the switch comes back on through the slew ramp.
// (R13) Switch not fully on within startup timeout after line high is a fault.
// (R14) A startup fault pulls the fault flag low, then latches or retries.
// (R15) Auto-retry waits the retry interval before restarting after a fault.
// (R16) Latch-off stays off until cleared; auto-retry restarts after a fixed delay.
// (R17) Comparator inputs are synchronised and intervals counted by clocked timers.
module efs_startup_protect_seq #(
   parameter int INSERTION_WAIT_CYC  = efs_pkg::INSERTION_WAIT_CYC,
   parameter int DRAIN_ENABLE_CYC    = efs_pkg::DRAIN_ENABLE_CYC,
   parameter int STARTUP_TIMEOUT_CYC = efs_pkg::STARTUP_TIMEOUT_CYC,
   parameter int RETRY_CYC           = efs_pkg::RETRY_CYC
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Comparator levels, asynchronous.
   input  wire logic        supply_low_guard,
   input  wire logic        input_ok,
   input  wire logic        enable_lockout_input,
   input  wire logic        enable_awake,
   input  wire logic        input_high_guard,
   input  wire logic        thermal_cutoff,
   input  wire logic        switch_full_on,
   // Shared open-drain switch-enable line.
   input  wire logic        shared_switch_on_line_in,
   output logic             shared_switch_on_line_out,
   output logic             shared_switch_on_line_oe,
   // Open-drain fault flag.
   output logic             fault_flag_out_out,
   output logic             fault_flag_out_oe,
   // Power stage controls.
   output logic             pass_switch_on,
   output logic             slew_ramp_control,
   output logic             quick_output_drain,
   // Interrupt.
   output logic             irq
);
   efs_pkg::efs_state_t state;
   efs_pkg::efs_state_t next_state;
   logic [7:0]          s_in;
   logic                s_bias;
   logic                s_vin;
   logic                s_en_on;
   logic                s_en_awake;
   logic                s_over;
   logic                s_hot;
   logic                s_line;
   logic                s_full;
   logic                seq_exp;
   logic                seq_load;
   logic [23:0]         seq_value;
   logic                drain_exp;
   logic                band;
   logic                band_q;
   logic                fault_latched;
   logic                next_fault_latched;
   logic                next_switch;
   logic                next_line_oe;
   logic                fault_event;
   logic                retry_en;
   logic                next_retry_en;
   logic [3:0]          irq_stat;
   logic [3:0]          next_irq_stat;
   logic [3:0]          irq_mask;
   logic [3:0]          next_irq_mask;
   logic [3:0]          irq_event;
   logic                next_pready;
   logic [31:0]         next_prdata;
   logic                next_pslverr;
   logic                acc;
   logic                wr;
   logic                rd;
   logic                clear_req;
   logic                supply_ok;

   // (R17) Two-stage synchronisers.
   efs_sync #(.WIDTH(8)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({switch_full_on, shared_switch_on_line_in, thermal_cutoff, input_high_guard,
                  enable_awake, enable_lockout_input, input_ok, supply_low_guard}),
      .sync_out (s_in)
   );
   assign {s_full, s_line, s_hot, s_over, s_en_awake, s_en_on, s_vin, s_bias} = s_in;
   // (R6) Both fixed lockouts.
   assign supply_ok = s_bias && s_vin;
   // (R7) Intermediate enable band.
   assign band = s_en_awake && !s_en_on;

   // (R17) Sequence interval timer.
   efs_timer u_seq_timer (
      .pclk       (pclk),
      .presetn    (presetn),
      .clear      (1'b0),
      .load       (seq_load),
      .load_value (seq_value),
      .expired    (seq_exp)
   );

   // (R8) Drain timer restarts on each entry into the band.
   efs_timer u_drain_timer (
      .pclk       (pclk),
      .presetn    (presetn),
      .clear      (!band),
      .load       (band && !band_q),
      .load_value (DRAIN_ENABLE_CYC[23:0]),
      .expired    (drain_exp)
   );

   // APB decode; one wait state so every read word comes from a register.
   assign acc       = psel && penable && pready;
   assign wr        = acc && pwrite;
   assign rd        = acc && !pwrite;
   assign clear_req = wr && paddr == efs_pkg::CTRL_OFS && pwdata[efs_pkg::CTRL_CLEAR_BIT];

   always_comb begin
      next_state         = state;
      next_fault_latched = fault_latched;
      fault_event        = 1'b0;
      // (R9) Shutdown level wipes all state, faults included.
      if (!s_en_awake) begin
         next_state         = efs_pkg::ST_OFF;
         next_fault_latched = 1'b0;
      // (R5) Thermal cutoff while conducting is a fault.
      end else if (s_hot && (state == efs_pkg::ST_START || state == efs_pkg::ST_ON)) begin
         next_state         = efs_pkg::ST_FAULT;
         next_fault_latched = 1'b1;
      end else begin
         case (state)
            efs_pkg::ST_OFF: begin
               // (R1) Both supplies good starts the insertion wait.
               if (supply_ok) begin
                  next_state = efs_pkg::ST_INSERT;
               end
            end
            efs_pkg::ST_INSERT: begin
               if (!supply_ok) begin
                  next_state = efs_pkg::ST_OFF;
               end else if (seq_exp) begin
                  next_state = efs_pkg::ST_READY;
               end
            end
            efs_pkg::ST_READY: begin
               // (R2) Sample enable and shared line together.
               if (!supply_ok) begin
                  next_state = efs_pkg::ST_OFF;
               end else if (s_en_on && s_line && !s_over) begin
                  next_state = efs_pkg::ST_START;
               end
            end
            efs_pkg::ST_START: begin
               if (!s_en_on || !s_line || s_over || !supply_ok) begin
                  next_state = efs_pkg::ST_READY;
               end else if (s_full) begin
                  next_state = efs_pkg::ST_ON;
               // (R13) Timeout without full turn-on.
               end else if (seq_exp) begin
                  next_state         = efs_pkg::ST_FAULT;
                  next_fault_latched = 1'b1;
                  fault_event        = 1'b1;
               end
            end
            efs_pkg::ST_ON: begin
               // (R11) Overvoltage drops back to wait for recovery.
               if (!s_en_on || !s_line || s_over || !supply_ok) begin
                  next_state = efs_pkg::ST_READY;
               end
            end
            efs_pkg::ST_FAULT: begin
               // (R16) Latch-off leaves only on a clear; retry after its delay.
               if (clear_req || (retry_en && seq_exp)) begin
                  next_state         = efs_pkg::ST_READY;
                  next_fault_latched = 1'b0;
               end
            end
            default: begin
               next_state = efs_pkg::ST_OFF;
            end
         endcase
      end
   end

   // (R15) Timer reload on entry to a timed state.
   always_comb begin
      seq_load  = (next_state != state);
      seq_value = 24'h000000;
      case (next_state)
         efs_pkg::ST_INSERT: seq_value = INSERTION_WAIT_CYC[23:0];
         efs_pkg::ST_START:  seq_value = STARTUP_TIMEOUT_CYC[23:0];
         efs_pkg::ST_FAULT:  seq_value = RETRY_CYC[23:0];
         default:            seq_load  = 1'b0;
      endcase
   end

   // (R3) (R10) Switch gated by enable, line, overvoltage and thermal every cycle.
   assign next_switch = (next_state == efs_pkg::ST_START || next_state == efs_pkg::ST_ON)
                        && s_en_on && s_line && !s_over && !s_hot;
   // (R4) Hold the shared line low whenever this device cannot conduct.
   assign next_line_oe = !(next_state == efs_pkg::ST_READY || next_state == efs_pkg::ST_START
                           || next_state == efs_pkg::ST_ON) || s_over || s_hot || !s_en_on;

   assign irq_event[efs_pkg::IRQ_STARTUP_FAULT] = fault_event;
   assign irq_event[efs_pkg::IRQ_THERMAL_CUT]   = s_hot && pass_switch_on;
   assign irq_event[efs_pkg::IRQ_OVERVOLT_CUT]  = s_over && pass_switch_on;
   assign irq_event[efs_pkg::IRQ_SWITCH_ON]     = next_state == efs_pkg::ST_ON
                                                  && state != efs_pkg::ST_ON;

   always_comb begin
      next_retry_en = retry_en;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_pready   = psel && penable && !pready;
      next_prdata   = 32'h00000000;
      next_pslverr  = 1'b0;
      if (wr && paddr == efs_pkg::CTRL_OFS) begin
         next_retry_en = pwdata[efs_pkg::CTRL_RETRY_BIT];
      end else if (wr && paddr == efs_pkg::IRQ_MASK_OFS) begin
         next_irq_mask = pwdata[3:0];
      end
      // Only bits already returned are cleared, so a late event is never lost.
      if (rd && paddr == efs_pkg::IRQ_STAT_OFS) begin
         next_irq_stat = irq_stat & ~prdata[3:0];
      end
      next_irq_stat = next_irq_stat | irq_event;
      if (psel && penable && !pready) begin
         if (paddr == efs_pkg::CTRL_OFS) begin
            next_prdata[efs_pkg::CTRL_RETRY_BIT] = retry_en;
         end else if (paddr == efs_pkg::STATUS_OFS) begin
            next_prdata[5:0]                      = state;
            next_prdata[efs_pkg::STAT_SWITCH_BIT] = pass_switch_on;
            next_prdata[efs_pkg::STAT_LINE_BIT]   = s_line;
            next_prdata[efs_pkg::STAT_FAULT_BIT]  = fault_latched;
            next_prdata[efs_pkg::STAT_DRAIN_BIT]  = quick_output_drain;
         end else if (paddr == efs_pkg::IRQ_STAT_OFS) begin
            next_prdata[3:0] = irq_stat;
         end else if (paddr == efs_pkg::IRQ_MASK_OFS) begin
            next_prdata[3:0] = irq_mask;
         end else begin
            next_pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state                     <= efs_pkg::ST_OFF;
         fault_latched             <= 1'b0;
         band_q                    <= 1'b0;
         pass_switch_on            <= 1'b0;
         slew_ramp_control         <= 1'b0;
         quick_output_drain        <= 1'b0;
         shared_switch_on_line_out <= 1'b0;
         shared_switch_on_line_oe  <= 1'b1;
         fault_flag_out_out        <= 1'b0;
         fault_flag_out_oe         <= 1'b0;
         retry_en                  <= efs_pkg::CTRL_RETRY_RST;
         irq_mask                  <= efs_pkg::IRQ_MASK_RST;
         irq_stat                  <= 4'h0;
         irq                       <= 1'b0;
         pready                    <= 1'b0;
         prdata                    <= 32'h00000000;
         pslverr                   <= 1'b0;
      end else begin
         state                     <= next_state;
         fault_latched             <= next_fault_latched;
         band_q                    <= band;
         pass_switch_on            <= next_switch;
         // (R12) Every turn-on, including overvoltage recovery, ramps.
         slew_ramp_control         <= next_switch && next_state == efs_pkg::ST_START;
         // (R8) Drain once the band has lasted past the drain time.
         quick_output_drain        <= band && drain_exp;
         shared_switch_on_line_out <= 1'b0;
         shared_switch_on_line_oe  <= next_line_oe;
         fault_flag_out_out        <= 1'b0;
         // (R14) Fault flag pulled low while a fault is latched.
         fault_flag_out_oe         <= next_fault_latched;
         retry_en                  <= next_retry_en;
         irq_mask                  <= next_irq_mask;
         irq_stat                  <= next_irq_stat;
         irq                       <= |(next_irq_stat & next_irq_mask);
         pready                    <= next_pready;
         prdata                    <= next_prdata;
         pslverr                   <= next_pslverr;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_overvolt_cut: assert property (s_over |=> !pass_switch_on) // (R11)
      else $error("switch still on after overvoltage");
   a_thermal_switch_cut: assert property (s_hot |=> !pass_switch_on) // (R5)
      else $error("switch still on under thermal cutoff");
   a_enable_line_gate: assert property ((!s_en_on || !s_line) |=> !pass_switch_on) // (R3)
      else $error("switch on with enable or line low");
   a_insert_hold_off: assert property (state == efs_pkg::ST_INSERT |=> !pass_switch_on) // (R10)
      else $error("switch on during insertion delay");
   a_insert_entry: assert property ( // (R1)
      state == efs_pkg::ST_OFF && supply_ok && s_en_awake |=> state == efs_pkg::ST_INSERT)
      else $error("insertion delay not started");
   a_start_sampled: assert property ( // (R2)
      state == efs_pkg::ST_START && $past(state) == efs_pkg::ST_READY |-> $past(s_en_on && s_line))
      else $error("start without enable and line");
   a_shutdown_wipe: assert property ( // (R9)
      !s_en_awake |=> state == efs_pkg::ST_OFF && !fault_latched)
      else $error("shutdown did not clear state");
   a_fault_flag_low: assert property ( // (R14)
      (state == efs_pkg::ST_FAULT)[*2] |-> fault_flag_out_oe && shared_switch_on_line_oe)
      else $error("fault not flagged");
   a_drain_band_only: assert property ( // (R8)
      quick_output_drain |-> $past(band) && $past(band, 2))
      else $error("drain outside intermediate band");
   a_latch_holds: assert property ( // (R16)
      state == efs_pkg::ST_FAULT && !retry_en && !clear_req && s_en_awake
      |=> state == efs_pkg::ST_FAULT)
      else $error("latch-off left fault state");

   c_switch_on:     cover property (state == efs_pkg::ST_START ##1 state == efs_pkg::ST_ON);
   c_startup_fault: cover property (fault_event);
   c_over_restart:  cover property (s_over && pass_switch_on ##[1:100] slew_ramp_control);
   c_drain:         cover property ($rose(quick_output_drain));
endmodule : efs_startup_protect_seq
`default_nettype wire

// File: efs_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module efs_peer_model (
   // Clock.
   input  wire logic       pclk,
   // Device side.
   input  wire logic       line_oe,
   input  wire logic       gate_on,
   // Scenario control.
   input  wire logic       peer_hold,
   input  wire logic       stall,
   input  wire logic [3:0] ramp_cyc,
   // Resolved levels.
   output logic            line,
   output logic            full_on
);
   logic [3:0] cnt;
   // Shared line level.
   // The line has a pull-up, so a peer that holds it low stops every device at once.
   assign line = !(line_oe || peer_hold);
   always_ff @(posedge pclk) begin
      if (!gate_on) begin
         cnt <= 4'h0;
      end else if (cnt != 4'hF) begin
         cnt <= cnt + 4'h1;
      end
   end
   // A stalled ramp never reaches full enhancement, which provokes the timeout.
   assign full_on = gate_on && !stall && (cnt >= ramp_cyc);
endmodule : efs_peer_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int INS = 20;
   localparam int DRN = 20;
   localparam int SUT = 50;
   localparam int RTY = 30;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'hF4BBE111;
   logic        sup = 1'b0, inok = 1'b0, en_on = 1'b0, awake = 1'b0, surge = 1'b0, hot = 1'b0;
   logic        peer_hold = 1'b1, stall = 1'b0, pready, pslverr, full_on, line, line_out;
   logic        line_oe, fault_out, fault_oe, sw, ramp, drain, irq;
   logic [3:0]  ramp_cyc = 4'h3;
   logic [32:0] exp_q[$];
   int          n_mismatch = 0, n_compared = 0, cyc = 0;

   always #12.5 pclk = ~pclk;

   efs_startup_protect_seq #(.INSERTION_WAIT_CYC(INS), .DRAIN_ENABLE_CYC(DRN),
      .STARTUP_TIMEOUT_CYC(SUT), .RETRY_CYC(RTY)) u_efs_startup_protect_seq (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .supply_low_guard(sup), .input_ok(inok), .enable_lockout_input(en_on),
      .enable_awake(awake), .input_high_guard(surge), .thermal_cutoff(hot),
      .switch_full_on(full_on), .shared_switch_on_line_in(line),
      .shared_switch_on_line_out(line_out), .shared_switch_on_line_oe(line_oe),
      .fault_flag_out_out(fault_out), .fault_flag_out_oe(fault_oe), .pass_switch_on(sw),
      .slew_ramp_control(ramp), .quick_output_drain(drain), .irq(irq));

   efs_peer_model u_efs_peer_model (.pclk(pclk), .line_oe(line_oe), .gate_on(sw),
      .peer_hold(peer_hold), .stall(stall), .ramp_cyc(ramp_cyc), .line(line),
      .full_on(full_on));

   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Requests are held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic wt(ref logic s, input logic v, input int n);
      for (int i = 0; i < n && s !== v; i++) @(posedge pclk);
      chk({32'h0, s}, {32'h0, v});
   endtask : wt

   task automatic hold(ref logic s, input logic v, input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         if (s !== v) bad = 1'b1;
      end
      chk({32'h0, bad}, 33'h0);
   endtask : hold

   // Forces a fresh start attempt by pulling the shared line low for a while.
   task automatic pulse;
      peer_hold <= 1'b1;
      // At least one edge passes so the hold is never overwritten in the same step.
      @(posedge pclk);
      wt(sw, 1'b0, 4);
      peer_hold <= 1'b0;
   endtask : pulse

   task automatic conclude;
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk({pslverr, prdata}, exp_q.pop_front());
      end
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({31'h0, sw, line_oe}, 33'h1);
      lfsr = nxt(lfsr);
      ramp_cyc <= lfsr[3:0] | 4'h1;
      sup <= 1'b1;
      inok <= 1'b1;
      awake <= 1'b1;
      en_on <= 1'b1;
      peer_hold <= 1'b0;
      hold(sw, 1'b0, INS);
      wt(sw, 1'b1, 10);
      chk({32'h0, ramp}, 33'h1);
      wt(ramp, 1'b0, 20);
      apb(1'b1, efs_pkg::IRQ_MASK_OFS, 32'h8);
      wt(irq, 1'b1, 4);
      rd(efs_pkg::IRQ_STAT_OFS, 33'h8);
      wt(irq, 1'b0, 4);
      rd(efs_pkg::STATUS_OFS, 33'hD0);
      lfsr = nxt(lfsr);
      apb(1'b1, 8'h10, lfsr);
      rd(8'h10, 33'h100000000);
      rd(efs_pkg::CTRL_OFS, 33'h0);
      pulse();
      wt(ramp, 1'b1, 8);
      wt(sw, 1'b1, 20);
      surge <= 1'b1;
      wt(sw, 1'b0, efs_pkg::OVERVOLTAGE_CUT_CYC);
      surge <= 1'b0;
      wt(ramp, 1'b1, 8);
      wt(ramp, 1'b0, 20);
      rd(efs_pkg::IRQ_STAT_OFS, 33'hC);
      stall <= 1'b1;
      pulse();
      wt(sw, 1'b1, 8);
      wt(fault_oe, 1'b1, SUT + 10);
      chk({32'h0, sw}, 33'h0);
      hold(sw, 1'b0, RTY + 10);
      rd(efs_pkg::IRQ_STAT_OFS, 33'h1);
      stall <= 1'b0;
      apb(1'b1, efs_pkg::CTRL_OFS, 32'h2);
      wt(sw, 1'b1, 10);
      wt(fault_oe, 1'b0, 40);
      apb(1'b1, efs_pkg::CTRL_OFS, 32'h1);
      stall <= 1'b1;
      pulse();
      wt(fault_oe, 1'b1, SUT + 20);
      stall <= 1'b0;
      hold(sw, 1'b0, RTY - 6);
      wt(sw, 1'b1, 14);
      wt(ramp, 1'b0, 20);
      hot <= 1'b1;
      wt(sw, 1'b0, 4);
      wt(fault_oe, 1'b1, 4);
      hot <= 1'b0;
      // Clear the thermal fault and select latch-off, so a fresh timeout must set the flag.
      apb(1'b1, efs_pkg::CTRL_OFS, 32'h2);
      stall <= 1'b1;
      pulse();
      wt(fault_oe, 1'b1, SUT + 20);
      en_on <= 1'b0;
      hold(drain, 1'b0, DRN - 4);
      wt(drain, 1'b1, 10);
      awake <= 1'b0;
      wt(fault_oe, 1'b0, 6);
      wt(drain, 1'b0, 6);
      rd(efs_pkg::STATUS_OFS, 33'h1);
      chk({31'h0, line_out, fault_out}, 33'h0);
      conclude();
   end
endmodule : testbench
`default_nettype wire
